// ===== shared/smem_pkg.sv
// Package: register map, field layout and timing constants of the static memory wait block
package smem_pkg;
    // Register byte offsets
    localparam logic [3:0]  CFG_OFFSET        = 4'h0;
    localparam logic [3:0]  STATUS_OFFSET     = 4'h4;
    // Configuration field positions
    localparam int          WIDTH_LSB         = 0;
    localparam int          NORMAL_WAIT_LSB   = 4;
    localparam int          BURST_WAIT_LSB    = 8;
    localparam int          BURST_EN_BIT      = 12;
    // Reset values
    localparam logic [3:0]  NORMAL_WAIT_RESET = 4'h0;
    localparam logic [3:0]  BURST_WAIT_RESET  = 4'h0;
    localparam logic [1:0]  WIDTH_RESET       = 2'h2;
    localparam logic        BURST_EN_RESET    = 1'b0;
    // Width codes
    localparam logic [1:0]  WIDTH_8           = 2'h2;
    localparam logic [1:0]  WIDTH_16          = 2'h1;
    localparam logic [1:0]  WIDTH_RSVD        = 2'h3;
    // Bus answers
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;
    // Wait count bases: burst 0..15, normal 1..16
    localparam logic [4:0]  BURST_WAIT_MAX    = 5'h0F;
    localparam logic [4:0]  NORMAL_WAIT_MAX   = 5'h10;
endpackage

// ===== core/wait_counter.sv
// Wait state down counter used to time external accesses
`timescale 1ns/1ps
`default_nettype none
module wait_counter
(
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       load_in,
    input  wire logic [4:0] count_in,
    output logic            busy_out
);
    logic [4:0] count_r;

    // Each count is one bus clock period
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
            count_r <= 5'h00;
        else if (load_in)
            count_r <= count_in;
        else if (count_r != 5'h00)
            count_r <= count_r - 5'h01;
    end

    assign busy_out = (count_r != 5'h00);
endmodule
`default_nettype wire

// ===== core/static_memory_wait_config.sv
// Static memory controller: wait configuration, access sequencing and AXI4-Lite registers
// What this block does
// [R01] Burst enable set: later burst beats faster
// [R02] Burst wait: 1111 zero, 0000 fifteen
// [R03] Normal wait: 1111 one, 0000 sixteen
// [R04] Width: 10 eight-bit, 01 sixteen-bit, 11 reserved
// [R05] First burst read uses normal wait
// [R06] Each wait state lasts one clock
// [R07] Sequential reads keep select and enable asserted
// [R08] Hold bus wait until count elapses
`timescale 1ns/1ps
`default_nettype none
module static_memory_wait_config
#(
    parameter int ADDR_W = 24
)
(
    input  wire logic              clk_in,
    input  wire logic              reset_n_in,
    // AXI4-Lite slave
    input  wire logic [3:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [3:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Internal system bus access request
    input  wire logic              sys_req_in,
    input  wire logic              sys_seq_in,
    input  wire logic              sys_write_in,
    input  wire logic [ADDR_W-1:0] sys_addr_in,
    input  wire logic [15:0]       sys_wdata_in,
    output logic                   bus_wait_hold_out,
    output logic                   sys_done_out,
    output logic [15:0]            sys_rdata_out,
    // External memory pins
    output logic [ADDR_W-1:0]      mem_addr_out,
    output logic                   mem_chip_select_n_out,
    output logic                   mem_output_enable_n_out,
    output logic                   mem_write_enable_n_out,
    output logic [15:0]            mem_data_out,
    output logic                   mem_data_oe_out,
    input  wire logic [15:0]       mem_data_in
);
    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    logic       burst_read_enable_r;
    logic [3:0] burst_wait_r;
    logic [3:0] normal_wait_r;
    logic [1:0] memory_width_select_r;
    logic       aw_held_r;
    logic       w_held_r;
    logic [3:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic       do_write;

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 4'h0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end
        else if (do_write)
            aw_held_r <= 1'b0;
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            w_held_r <= 1'b0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end
        else if (do_write)
            w_held_r <= 1'b0;
    end

    assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            burst_read_enable_r   <= smem_pkg::BURST_EN_RESET;
            burst_wait_r          <= smem_pkg::BURST_WAIT_RESET;
            normal_wait_r         <= smem_pkg::NORMAL_WAIT_RESET;
            memory_width_select_r <= smem_pkg::WIDTH_RESET;
        end
        else if (do_write && aw_addr_r == smem_pkg::CFG_OFFSET)
        begin
            if (w_strb_r[0])
            begin
                // Reserved width code is refused, previous width kept
                if (w_data_r[smem_pkg::WIDTH_LSB +: 2] != smem_pkg::WIDTH_RSVD) // [R04]
                    memory_width_select_r <= w_data_r[smem_pkg::WIDTH_LSB +: 2];
                normal_wait_r <= w_data_r[smem_pkg::NORMAL_WAIT_LSB +: 4];
            end
            if (w_strb_r[1])
            begin
                burst_wait_r        <= w_data_r[smem_pkg::BURST_WAIT_LSB +: 4];
                burst_read_enable_r <= w_data_r[smem_pkg::BURST_EN_BIT];
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= smem_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_r == smem_pkg::CFG_OFFSET) ? smem_pkg::RESP_OKAY
                                                                : smem_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // ----------------------------------------
    // Access sequencer
    // ----------------------------------------
    typedef enum logic [2:0]
    {
        IDLE_S   = 3'b001,
        WAIT_S   = 3'b010,
        FINISH_S = 3'b100
    } state_type;

    state_type   state_r;
    logic        load;
    logic [4:0]  load_count;
    logic        waiting;
    logic        in_burst_r;
    logic        seq_ok;

    // Sequential reads keep the strobes; a new non-sequential access restarts
    assign seq_ok = sys_seq_in && !sys_write_in && !mem_chip_select_n_out; // [R07]

    // Burst beats use burst count only after the first beat of the burst
    always_comb
    begin
        if (burst_read_enable_r && seq_ok && in_burst_r) // [R01] [R05]
            load_count = smem_pkg::BURST_WAIT_MAX - {1'b0, burst_wait_r}; // [R02]
        else
            load_count = smem_pkg::NORMAL_WAIT_MAX - {1'b0, normal_wait_r}; // [R03]
    end

    assign load = (state_r == IDLE_S) && sys_req_in;

    wait_counter u_wait
    (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .load_in    (load),
        .count_in   (load_count),
        .busy_out   (waiting)
    );

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
            state_r <= IDLE_S;
        else
        begin
            unique case (state_r)
                IDLE_S:   if (sys_req_in) state_r <= WAIT_S;
                WAIT_S:   if (!waiting || load_count == 5'h00) state_r <= FINISH_S; // [R06]
                FINISH_S: state_r <= IDLE_S;
                default:  state_r <= IDLE_S;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
            in_burst_r <= 1'b0;
        else if (state_r == FINISH_S)
            in_burst_r <= !sys_write_in;
        else if (load && !seq_ok)
            in_burst_r <= 1'b0;
    end

    // Wait held from request until the counted states run out
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
            bus_wait_hold_out <= 1'b0;
        else
            bus_wait_hold_out <= load || (state_r == WAIT_S && waiting); // [R08]
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            sys_done_out  <= 1'b0;
            sys_rdata_out <= 16'h0000;
        end
        else
        begin
            sys_done_out <= (state_r == WAIT_S) && !waiting; // [R08]
            if ((state_r == WAIT_S) && !waiting)
                sys_rdata_out <= (memory_width_select_r == smem_pkg::WIDTH_8) // [R04]
                               ? {8'h00, mem_data_in[7:0]} : mem_data_in;
        end
    end

    // Pin drive: strobes held after a read, so select stays low while idle
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            mem_addr_out            <= '0;
            mem_chip_select_n_out   <= 1'b1;
            mem_output_enable_n_out <= 1'b1;
            mem_write_enable_n_out  <= 1'b1;
            mem_data_out            <= 16'h0000;
            mem_data_oe_out         <= 1'b0;
        end
        else if (load)
        begin
            mem_addr_out            <= sys_addr_in;
            mem_chip_select_n_out   <= 1'b0;
            mem_output_enable_n_out <= sys_write_in;
            mem_write_enable_n_out  <= !sys_write_in;
            mem_data_out            <= sys_wdata_in;
            mem_data_oe_out         <= sys_write_in;
        end
        else if (state_r == FINISH_S && sys_write_in) // [R07]
        begin
            mem_chip_select_n_out   <= 1'b1;
            mem_output_enable_n_out <= 1'b1;
            mem_write_enable_n_out  <= 1'b1;
            mem_data_oe_out         <= 1'b0;
        end
    end

    // ----------------------------------------
    // Register read port
    // ----------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= smem_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= smem_pkg::RESP_OKAY;
            if (s_axi_araddr == smem_pkg::CFG_OFFSET)
                s_axi_rdata <= {19'h00000, burst_read_enable_r, burst_wait_r,
                                normal_wait_r, 2'h0, memory_width_select_r};
            else if (s_axi_araddr == smem_pkg::STATUS_OFFSET)
                s_axi_rdata <= {29'h00000000, state_r};
            else
            begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= smem_pkg::RESP_SLVERR;
            end
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else
            s_axi_arready <= 1'b1;
    end
endmodule
`default_nettype wire

// ===== sim/smem_props.sv
// Checker: port assertions of the static memory wait block
`timescale 1ns/1ps
`default_nettype none
module smem_props
(
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    input  wire logic sys_req_in,
    input  wire logic sys_seq_in,
    input  wire logic sys_write_in,
    input  wire logic sys_done_out,
    input  wire logic bus_wait_hold_out,
    input  wire logic mem_chip_select_n_out,
    input  wire logic mem_output_enable_n_out,
    input  wire logic mem_write_enable_n_out,
    input  wire logic mem_data_oe_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // Sixteen waits plus overhead is the longest legal access
    a_done_bounded: assert property ($rose(sys_req_in) |-> ##[2:24] sys_done_out)
        else $error("access not completed in time");
    a_wait_ends: assert property ($rose(bus_wait_hold_out) |-> ##[1:20] !bus_wait_hold_out)
        else $error("wait hold too long");
    a_done_after_wait: assert property (sys_done_out |-> !bus_wait_hold_out)
        else $error("done while still waiting");
    a_done_pulse: assert property (sys_done_out |=> !sys_done_out)
        else $error("done longer than one cycle");
    a_done_needs_req: assert property (sys_done_out |-> $past(sys_req_in))
        else $error("done without request");
    a_read_strobes: assert property (!mem_output_enable_n_out |->
        !mem_chip_select_n_out && !mem_data_oe_out)
        else $error("read enable without select");
    a_write_strobe: assert property (!mem_write_enable_n_out |->
        !mem_chip_select_n_out && mem_output_enable_n_out)
        else $error("write enable without select");
    a_seq_keeps_cs: assert property ($rose(sys_req_in) && sys_seq_in && !sys_write_in |->
        !mem_chip_select_n_out)
        else $error("select dropped before sequential beat");
    c_seq: cover property ($rose(sys_req_in) && sys_seq_in);
    c_write: cover property (!mem_write_enable_n_out);
    c_wait: cover property ($fell(bus_wait_hold_out));
endmodule
bind static_memory_wait_config smem_props u_props (.*);
`default_nettype wire

// ===== sim/ext_mem_model.sv
// Partner: external static memory answering reads with an address pattern
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model
(
    input  wire logic [23:0] addr_in,
    input  wire logic        clk_in,
    input  wire logic        cs_n_in,
    input  wire logic        oe_n_in,
    output logic      [15:0] data_out
);
    logic [15:0] junk_r = 16'hC3C3;
    // Released bus churns every cycle so stale data is never taken as valid
    always_ff @(posedge clk_in)
        junk_r <= junk_r + 16'h1357;
    assign data_out = (!cs_n_in && !oe_n_in) ? addr_in[15:0] ^ 16'h5A3C : junk_r;
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Testbench: register access and wait timing of the static memory block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk_in = 1'b0, reset_n_in = 1'b0, gap = 1'b0, run = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, bus_wait_hold_out, sys_done_out;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        sys_req_in = 1'b0, sys_seq_in = 1'b0, sys_write_in = 1'b0;
    logic [23:0] sys_addr_in = 24'h0, mem_addr_out;
    logic [15:0] sys_wdata_in = 16'h0, sys_rdata_out, mem_data_out, mem_data_in;
    logic        mem_chip_select_n_out, mem_output_enable_n_out;
    logic        mem_write_enable_n_out, mem_data_oe_out;
    int          n_fail = 0, n_compared = 0, cyc = 0, lat, l0, s[3];
    logic [3:0]  nib[3] = '{4'hF, 4'h7, 4'h0};
    logic [31:0] cf[3] = '{32'h0F01, 32'h1F01, 32'h1001};
    logic [31:0] wcap = 32'h0;
    static_memory_wait_config DUT (.*);
    ext_mem_model u_mem (.addr_in(mem_addr_out), .clk_in(clk_in), .cs_n_in(mem_chip_select_n_out),
        .oe_n_in(mem_output_enable_n_out), .data_out(mem_data_in));
    initial forever #25 clk_in = ~clk_in;
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (run && mem_chip_select_n_out) gap <= 1'b1;
        // Capture what the pins present while the write strobe is low
        if (!mem_write_enable_n_out && mem_data_oe_out) wcap <= {mem_addr_out[15:0], mem_data_out};
        if (cyc == 20000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_in);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk_in);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_in);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk_in);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Latency counts edges from launch to the done pulse
    task automatic acc(input logic sq, input logic w, input logic [23:0] a);
        @(posedge clk_in);
        sys_req_in <= 1'b1;
        sys_seq_in <= sq;
        sys_write_in <= w;
        sys_addr_in <= a;
        sys_wdata_in <= a[15:0];
        lat = 0;
        do
        begin
            @(posedge clk_in);
            lat++;
        end while (sys_done_out !== 1'b1);
        d = {16'h0, sys_rdata_out};
        sys_req_in <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rd(smem_pkg::CFG_OFFSET);
        chk(d, 32'h2);
        rd(4'h8);
        chk({30'h0, r}, {30'h0, smem_pkg::RESP_SLVERR});
        wr(4'h8, 32'h1);
        chk({30'h0, r}, {30'h0, smem_pkg::RESP_SLVERR});
        for (int i = 0; i < 3; i++)
        begin
            wr(smem_pkg::CFG_OFFSET, {24'h0, nib[i], 4'h1});
            acc(1'b0, 1'b0, 24'h001230 + i);
            chk(d, {16'h0, 16'h1230 ^ 16'h5A3C ^ i[15:0]});
            s[i] = lat;
        end
        chk(s[1] - s[0], 8);
        chk(s[2] - s[0], 15);
        l0 = s[2];
        // Reserved width code must leave the previous width in place
        wr(smem_pkg::CFG_OFFSET, 32'h3);
        rd(smem_pkg::CFG_OFFSET);
        chk(d, 32'h1);
        wr(smem_pkg::CFG_OFFSET, 32'h2);
        acc(1'b0, 1'b0, 24'h000456);
        chk(d, 32'h0000006A);
        acc(1'b0, 1'b1, 24'h000789);
        chk(wcap, 32'h07890789);
        for (int i = 0; i < 3; i++)
        begin
            wr(smem_pkg::CFG_OFFSET, cf[i]);
            acc(1'b0, 1'b0, 24'h002000);
            chk(lat, l0);
            run <= (i == 1);
            acc(1'b1, 1'b0, 24'h002002);
            s[i] = lat;
            chk(d, 32'h7A3E);
            acc(1'b1, 1'b0, 24'h002004);
            chk(d, 32'h7A38);
            run <= 1'b0;
        end
        chk({31'h0, gap}, 32'h0);
        chk(s[0] - s[1], 16);
        chk(s[2] - s[1], 15);
        tally_and_finish();
    end
endmodule
`default_nettype wire
